// ---- pdspc_defs.svh ----
// offsets, field positions, reset values and timing counts of the power control block
`ifndef PDSPC_DEFS_SVH
`define PDSPC_DEFS_SVH
// clock rate and the supply-off hold time after a fault
`define PDSPC_CLK_MHZ 200
`define PDSPC_OFF_TIME_US 1000
`define PDSPC_OFF_CYC (`PDSPC_OFF_TIME_US * `PDSPC_CLK_MHZ)
// overvoltage trip and discharge stop, percent of the selected voltage
`define PDSPC_OVP_PCT 8'h6e
`define PDSPC_DISCH_PCT 8'h6e
// register byte offsets
`define PDSPC_ADR_CTRL 4'h0
`define PDSPC_ADR_STATE 4'h4
`define PDSPC_ADR_ISTAT 4'h8
`define PDSPC_ADR_IMASK 4'hc
// control fields
`define PDSPC_CTRL_GO 0
`define PDSPC_CTRL_DROP 1
`define PDSPC_CTRL_IDX_LSB 4
// state register fields
`define PDSPC_ST_IDX_LSB 4
`define PDSPC_ST_DISCH 8
`define PDSPC_ST_PROF_LSB 12
// event bits, shared by status and mask
`define PDSPC_EV_PLUG 0
`define PDSPC_EV_OVP 1
`define PDSPC_EV_SYSF 2
`define PDSPC_EV_DISCH 3
`define PDSPC_EV_BADREQ 4
`define PDSPC_EV_RENEG 5
`define PDSPC_NEV 6
`define PDSPC_IMASK_RST 6'h00
// supported voltages in mV, slot 0 lowest, 0 marks a reserved slot
`define PDSPC_PROF0 {16'h4e20, 16'h2ee0, 16'h2328, 16'h1388}
`define PDSPC_PROF1 {16'h0000, 16'h4e20, 16'h2328, 16'h1388}
`define PDSPC_PROF2 {16'h0000, 16'h4e20, 16'h2ee0, 16'h1388}
`define PDSPC_PROF3 {16'h4e20, 16'h3a98, 16'h2328, 16'h1388}
`endif

// ---- pdspc_pkg.sv ----
// types of the power control block
`default_nettype none
package pdspc_pkg;
  // one-hot states of the supply sequencer
  typedef enum logic [3:0] {
    st_wait = 4'h1,
    st_safe = 4'h2,
    st_contract = 4'h4,
    st_off = 4'h8
  } pdspc_state_e;
  // a bus voltage in mV
  typedef logic [15:0] pdspc_mv_t;
endpackage
`default_nettype wire

// ---- pdspc_sel_if.sv ----
// interface between the sequencer and the voltage select encoder
`timescale 1ns/10ps
`default_nettype none
interface pdspc_sel_if;
  import pdspc_pkg::*;
  logic [1:0] profile; // latched profile
  logic [1:0] idx; // selected voltage slot
  logic [2:0] count; // voltages in this profile
  pdspc_mv_t target_mv; // voltage of the selected slot
  logic [3:0] lines_n; // one-per-voltage lines, active low
  modport enc (input profile, idx, output count, target_mv, lines_n);
  modport user (output profile, idx, input count, target_mv, lines_n);
endinterface
`default_nettype wire

// ---- pdspc_vsel.sv ----
// voltage select encoder: profile table, slot count, select lines
`timescale 1ns/10ps
`default_nettype none
`include "pdspc_defs.svh"
module pdspc_vsel
  import pdspc_pkg::*;
(
  pdspc_sel_if.enc sel
);
  // table row of one profile, four slots of 16 bits
  function automatic logic [63:0] prof_row(input logic [1:0] p);
    logic [63:0] row;
    row = `PDSPC_PROF0;
    unique case (p)
      2'h0: row = `PDSPC_PROF0;
      2'h1: row = `PDSPC_PROF1;
      2'h2: row = `PDSPC_PROF2;
      2'h3: row = `PDSPC_PROF3;
    endcase
    return row;
  endfunction

  // the profile alone fixes which voltages the codes map to
  always_comb begin
    logic [63:0] row;
    row = prof_row(sel.profile);
    // reserved slots carry a zero voltage
    sel.count = (row[63:48] == 16'h0000) ? 3'h3 : 3'h4;
    sel.target_mv = row[sel.idx*16 +: 16];
    // one line per slot, ascending order, low on the selected one
    sel.lines_n = ~(4'h1 << sel.idx);
  end
endmodule
`default_nettype wire

// ---- pdspc_top.sv ----
// power path control of a power delivery source
//
// Decided for this implementation: the address-and-strobe port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
`include "pdspc_defs.svh"
// Operation
// - supply enable low while supplying vbus
// - low plug detect starts supply, idles high
// - fault output asserted on supply exception
// - binary code ascends, code zero lowest
// - reserved binary codes never driven
// - one active-low line per voltage
// - lines beyond voltage count never asserted
// - overvoltage when bus exceeds selection by 10% (check rests while a discharge is in progress)
// - discharge on every step down
// - discharge stops at fraction of destination
// - charger emulation on at safe 5V
// - charger emulation off under any contract
// - profile pins fix voltage mapping
// - fault cycles supply off, on, renegotiate
module pdspc_top
  import pdspc_pkg::*;
#(
  parameter int unsigned OFF_CYCLES = `PDSPC_OFF_CYC
) (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic irq,
  input wire logic plug_detect_n,
  input wire logic system_fault_in,
  input wire logic profile_select_0,
  input wire logic profile_select_1,
  input wire logic [15:0] mon_mv,
  input wire logic mon_valid,
  output logic supply_enable_n,
  output logic volt_code_bit0,
  output logic volt_code_bit1,
  output logic volt_line0_n,
  output logic volt_line1_n,
  output logic volt_line2_n,
  output logic volt_line3_n,
  output logic bus_discharge_enable,
  output logic charger_emulation_enable,
  output logic fault_n_o,
  output logic fault_n_oe
);
  // percentage of a voltage, wide enough for 16 x 8 bits
  function automatic logic [23:0] mv_scale(input pdspc_mv_t mv,
                                           input logic [7:0] pct);
    return ({8'h00, mv} * {16'h0000, pct}) / 24'h000064;
  endfunction

  // pin synchronisers: plug, system fault, two profile pins
  logic [3:0] sync_a_r; // first stage, read only by sync_b_r
  logic [3:0] sync_b_r; // second stage
  logic plug_s; // low while a plug is detected
  logic sysf_s; // system fault level
  pdspc_state_e state_r; // sequencer state
  logic [1:0] profile_r; // profile latched while idle
  logic [1:0] idx_r; // selected voltage slot
  logic [31:0] off_cnt_r; // supply-off hold countdown
  logic disch_r; // discharge in progress
  logic [`PDSPC_NEV-1:0] istat_r; // sticky events
  logic [`PDSPC_NEV-1:0] imask_r; // event enables
  logic [`PDSPC_NEV-1:0] ev; // events this cycle
  logic irq_r;
  logic [31:0] rdata_r;
  logic en_n_r;
  logic [1:0] code_r;
  logic [3:0] lines_r;
  logic chg_r;
  logic fault_oe_r;

  // encoder shared by selection, overvoltage and discharge
  pdspc_sel_if sel_if();
  assign sel_if.profile = profile_r;
  assign sel_if.idx = idx_r;
  pdspc_vsel u_vsel (
    .sel(sel_if.enc)
  );

  // plug idles high so its stages reset high
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      sync_a_r <= 4'h1;
      sync_b_r <= 4'h1;
    end else begin
      sync_a_r <= {profile_select_1, profile_select_0,
                   system_fault_in, plug_detect_n};
      sync_b_r <= sync_a_r;
    end
  end
  assign plug_s = sync_b_r[0];
  assign sysf_s = sync_b_r[1];

  // request decode from the control register
  logic wr_ctrl;
  logic [1:0] req_idx;
  logic live; // supply is up
  logic req_ok; // accepted contract request
  logic bad_req; // request out of range or while down
  logic drop; // contract dropped back to safe level
  logic lower; // new slot below the current one
  logic ovp_hit;
  logic stop_hit;
  logic fault_go;
  logic off_done;
  always_comb begin
    wr_ctrl = reg_wr && (reg_addr == `PDSPC_ADR_CTRL);
    req_idx = reg_wdata[`PDSPC_CTRL_IDX_LSB +: 2];
    live = (state_r == st_safe) || (state_r == st_contract);
    // codes at or beyond the count are reserved
    req_ok = wr_ctrl && reg_wdata[`PDSPC_CTRL_GO] && live &&
             ({1'b0, req_idx} < sel_if.count);
    bad_req = wr_ctrl && reg_wdata[`PDSPC_CTRL_GO] && !req_ok;
    drop = wr_ctrl && reg_wdata[`PDSPC_CTRL_DROP] &&
           !reg_wdata[`PDSPC_CTRL_GO] && (state_r == st_contract);
    lower = (req_ok && (req_idx < idx_r)) ||
            (drop && (idx_r != 2'h0));
    // overvoltage against the selected slot; a step down is expected
    // to sit high until discharged, so the check rests meanwhile
    ovp_hit = live && mon_valid && !disch_r &&
              ({8'h00, mon_mv} >
               mv_scale(sel_if.target_mv, `PDSPC_OVP_PCT));
    stop_hit = disch_r && mon_valid &&
               ({8'h00, mon_mv} <=
                mv_scale(sel_if.target_mv, `PDSPC_DISCH_PCT));
    fault_go = live && (ovp_hit || sysf_s);
    off_done = (state_r == st_off) && (off_cnt_r == 32'h0);
  end

  // sequencer: wait for plug, safe level, contract, supply off
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_r <= st_wait;
    end else begin
      unique case (state_r)
        st_wait: begin
          if (!plug_s) begin
            state_r <= st_safe;
          end
        end
        st_safe: begin
          if (fault_go) begin
            state_r <= st_off;
          end else if (plug_s) begin
            state_r <= st_wait;
          end else if (req_ok) begin
            state_r <= st_contract;
          end
        end
        st_contract: begin
          if (fault_go) begin
            state_r <= st_off;
          end else if (plug_s) begin
            state_r <= st_wait;
          end else if (drop) begin
            state_r <= st_safe;
          end
        end
        st_off: begin
          // supply back on and negotiation restarts; a fault that is
          // still present sends it round again
          if (off_done) begin
            state_r <= st_safe;
          end
        end
      endcase
    end
  end

  // supply-off hold time
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      off_cnt_r <= 32'h0;
    end else if (fault_go) begin
      off_cnt_r <= 32'(OFF_CYCLES - 1);
    end else if (off_cnt_r != 32'h0) begin
      off_cnt_r <= off_cnt_r - 32'h1;
    end
  end

  // profile only follows the pins while no plug is served
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      profile_r <= 2'h0;
    end else if (state_r == st_wait) begin
      profile_r <= sync_b_r[3:2];
    end
  end

  // selected slot: lowest after any loss of contract
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      idx_r <= 2'h0;
    end else if (fault_go || !live) begin
      idx_r <= 2'h0;
    end else if (req_ok) begin
      idx_r <= req_idx;
    end else if (drop) begin
      idx_r <= 2'h0;
    end
  end

  // discharge from each step down until the fraction is reached
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      disch_r <= 1'b0;
    end else if (lower) begin
      disch_r <= 1'b1;
    end else if (stop_hit || state_r == st_wait) begin
      disch_r <= 1'b0;
    end
  end

  // events; a set in the cycle of its clear survives
  always_comb begin
    ev = '0;
    ev[`PDSPC_EV_PLUG] = (state_r == st_wait) && !plug_s;
    ev[`PDSPC_EV_OVP] = ovp_hit;
    ev[`PDSPC_EV_SYSF] = live && sysf_s;
    ev[`PDSPC_EV_DISCH] = stop_hit;
    ev[`PDSPC_EV_BADREQ] = bad_req;
    ev[`PDSPC_EV_RENEG] = off_done;
  end
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      istat_r <= '0;
    end else if (reg_wr && reg_addr == `PDSPC_ADR_ISTAT) begin
      istat_r <= (istat_r & ~reg_wdata[`PDSPC_NEV-1:0]) | ev;
    end else begin
      istat_r <= istat_r | ev;
    end
  end

  // mask register
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      imask_r <= `PDSPC_IMASK_RST;
    end else if (reg_wr && reg_addr == `PDSPC_ADR_IMASK) begin
      imask_r <= reg_wdata[`PDSPC_NEV-1:0];
    end
  end

  // level interrupt, one cycle behind the status
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(istat_r & imask_r);
    end
  end

  // read data stand only in the cycle after the strobe
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_r <= 32'h0;
    end else if (reg_rd) begin
      rdata_r <= 32'h0;
      unique case (reg_addr)
        `PDSPC_ADR_CTRL: begin
          rdata_r[`PDSPC_CTRL_IDX_LSB +: 2] <= idx_r;
        end
        `PDSPC_ADR_STATE: begin
          rdata_r[3:0] <= state_r;
          rdata_r[`PDSPC_ST_IDX_LSB +: 2] <= idx_r;
          rdata_r[`PDSPC_ST_DISCH] <= disch_r;
          rdata_r[`PDSPC_ST_PROF_LSB +: 2] <= profile_r;
        end
        `PDSPC_ADR_ISTAT: begin
          rdata_r[`PDSPC_NEV-1:0] <= istat_r;
        end
        `PDSPC_ADR_IMASK: begin
          rdata_r[`PDSPC_NEV-1:0] <= imask_r;
        end
        default: begin
          rdata_r <= 32'h0; // unmapped reads as zero
        end
      endcase
    end else begin
      rdata_r <= 32'h0;
    end
  end

  // pin registers, one cycle behind the sequencer
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      en_n_r <= 1'b1;
      code_r <= 2'h0;
      lines_r <= 4'he;
      chg_r <= 1'b0;
    end else begin
      en_n_r <= !live;
      code_r <= idx_r;
      lines_r <= sel_if.lines_n;
      chg_r <= (state_r == st_safe);
    end
  end

  // fault pin from detection until the restart begins
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      fault_oe_r <= 1'b0;
    end else begin
      fault_oe_r <= fault_go ||
                    (state_r == st_off && !off_done);
    end
  end

  assign reg_rdata = rdata_r;
  assign irq = irq_r;
  assign supply_enable_n = en_n_r;
  assign volt_code_bit0 = code_r[0];
  assign volt_code_bit1 = code_r[1];
  assign volt_line0_n = lines_r[0];
  assign volt_line1_n = lines_r[1];
  assign volt_line2_n = lines_r[2];
  assign volt_line3_n = lines_r[3];
  assign bus_discharge_enable = disch_r;
  assign charger_emulation_enable = chg_r;
  assign fault_n_o = 1'b0; // open drain only ever pulls low
  assign fault_n_oe = fault_oe_r;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  a_supply_on:
    assert property (state_r == st_contract |=> !supply_enable_n)
    else $error("supply enable high under a contract");
  a_plug_start:
    assert property (state_r == st_wait && !plug_s |=> state_r == st_safe)
    else $error("plug detect did not start the supply");
  a_fault_pin:
    assert property (fault_go |=> fault_n_oe ##1 state_r == st_off)
    else $error("fault not shown after exception");
  a_code_follow:
    assert property (req_ok |-> ##2
      ({volt_code_bit1, volt_code_bit0} == $past(req_idx, 2)))
    else $error("binary code not the requested slot");
  a_code_reserved:
    assert property ({1'b0, code_r} < sel_if.count)
    else $error("reserved binary code driven");
  a_line_onehot:
    assert property ($countones(~lines_r) == 1 && !lines_r[code_r])
    else $error("select lines not one-hot on the code");
  a_line_spare:
    assert property (sel_if.count == 3'h3 && $stable(profile_r)
                     |-> lines_r[3])
    else $error("reserved select line asserted");
  a_ovp_trip:
    assert property (ovp_hit |=> state_r == st_off)
    else $error("overvoltage did not shut the supply");
  a_disch_start:
    assert property (lower |=> bus_discharge_enable)
    else $error("no discharge on a step down");
  a_disch_stop:
    assert property (stop_hit && !lower |=> !bus_discharge_enable)
    else $error("discharge kept past the stop level");
  a_emu_safe:
    assert property (state_r == st_safe |=> charger_emulation_enable)
    else $error("charger emulation off at safe level");
  a_emu_contract:
    assert property (state_r == st_contract |=> !charger_emulation_enable)
    else $error("charger emulation on under a contract");
  a_profile_hold:
    assert property (state_r != st_wait |=> $stable(profile_r))
    else $error("profile changed while serving");
  a_off_restart:
    assert property (off_done |=> state_r == st_safe ##1 !supply_enable_n)
    else $error("supply not restarted after hold");
  a_fault_hold:
    assert property (state_r == st_off && !off_done |=> fault_n_oe)
    else $error("fault released before restart");

  c_contract: cover property (state_r == st_safe ##1 state_r == st_contract);
  c_ovp: cover property (ovp_hit);
  c_discharge: cover property (lower ##[1:50] stop_hit);
  c_restart: cover property (off_done);
endmodule
`default_nettype wire

// ---- pdspc_supply_model.sv ----
// behavioural power supply and bus voltage monitor facing the select pins
`timescale 1ns/10ps
`default_nettype none
module pdspc_supply_model (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic supply_enable_n,
  input wire logic [3:0] lines_n,
  input wire logic [1:0] profile,
  input wire logic discharge,
  input wire logic overshoot,
  output logic [15:0] mon_mv,
  output logic mon_valid
);
  // supply rails per profile in mv, 0 marks an unused slot
  int tbl [4][4] = '{'{5000, 9000, 12000, 20000}, '{5000, 9000, 20000, 0},
    '{5000, 12000, 20000, 0}, '{5000, 9000, 15000, 20000}};
  int v; // bus voltage in mv
  int t; // regulation target
  int ph; // sample phase, one sample every four cycles
  // rail follows the lines; it sags slowly unless the switch discharges it
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      v = 0;
      ph = 0;
      mon_valid <= 1'b0;
      mon_mv <= 16'h0;
    end else begin
      t = 0;
      for (int i = 0; i < 4; i++) begin
        if (!lines_n[i]) t = tbl[profile][i];
      end
      // load drains an unpowered bus at once, so a restart starts clean
      if (supply_enable_n) v = 0;
      else if (v < t) v = (v + 2000 > t) ? t : v + 2000;
      else if (discharge) v = (v > 1000) ? v - 1000 : 0;
      else if (v > t) v = (v - 100 < t) ? t : v - 100;
      ph = (ph + 1) % 4;
      mon_valid <= (ph == 0);
      // between samples the word is not held, it toggles
      mon_mv <= (ph == 0) ? 16'(overshoot ? v + v / 8 : v) : ~mon_mv;
    end
  end
endmodule
`default_nettype wire

// ---- pdspc_top_tb_top.sv ----
// self-checking bench of the power control block
`timescale 1ns/10ps
`default_nettype none
module pdspc_top_tb_top;
  import pdspc_pkg::*;
  logic sys_clk = 1'b0, arst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0, reg_rdata;
  logic plug_detect_n = 1'b1, system_fault_in = 1'b0, ovr = 1'b0;
  logic profile_select_0 = 1'b0, profile_select_1 = 1'b0;
  logic [15:0] mon_mv, last_mv; // last_mv: last valid monitor word
  logic mon_valid, irq, supply_enable_n, volt_code_bit0, volt_code_bit1;
  logic volt_line0_n, volt_line1_n, volt_line2_n, volt_line3_n;
  logic bus_discharge_enable, charger_emulation_enable;
  logic fault_n_o, fault_n_oe;
  wire fault_pin = fault_n_oe ? fault_n_o : 1'b1; // board pull-up
  wire [3:0] lines = {volt_line3_n, volt_line2_n, volt_line1_n, volt_line0_n};
  int fail_count = 0, n_tests = 0;
  // expected rails per profile in mv, 0 marks an unused slot
  int tbl [4][4] = '{'{5000, 9000, 12000, 20000}, '{5000, 9000, 20000, 0},
    '{5000, 12000, 20000, 0}, '{5000, 9000, 15000, 20000}};
  always #2.5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) if (mon_valid) last_mv <= mon_mv;
  // short supply-off hold keeps restarts quick
  pdspc_top #(.OFF_CYCLES(8)) i_dut (.sys_clk(sys_clk), .arst_n(arst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
    .plug_detect_n(plug_detect_n), .system_fault_in(system_fault_in),
    .profile_select_0(profile_select_0), .profile_select_1(profile_select_1),
    .mon_mv(mon_mv), .mon_valid(mon_valid), .supply_enable_n(supply_enable_n),
    .volt_code_bit0(volt_code_bit0), .volt_code_bit1(volt_code_bit1),
    .volt_line0_n(volt_line0_n), .volt_line1_n(volt_line1_n),
    .volt_line2_n(volt_line2_n), .volt_line3_n(volt_line3_n),
    .bus_discharge_enable(bus_discharge_enable),
    .charger_emulation_enable(charger_emulation_enable),
    .fault_n_o(fault_n_o), .fault_n_oe(fault_n_oe));
  pdspc_supply_model i_supply (.sys_clk(sys_clk), .arst_n(arst_n),
    .supply_enable_n(supply_enable_n), .lines_n(lines),
    .profile({profile_select_1, profile_select_0}),
    .discharge(bus_discharge_enable), .overshoot(ovr), .mon_mv(mon_mv),
    .mon_valid(mon_valid));
  // verdict and end of run, also reached from a timed-out wait
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
      fail_count++;
    end
  endtask
  // one-cycle register strobes, changed just after the edge
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  function automatic logic cnd(input int k);
    case (k)
      0: return supply_enable_n === 1'b0;
      1: return bus_discharge_enable === 1'b0;
      2: return fault_n_oe === 1'b1;
      default: return supply_enable_n === 1'b1;
    endcase
  endfunction
  // bounded wait; running out ends the run as a mismatch
  task automatic wait_for(input int k, input int lim);
    repeat (lim) if (!cnd(k)) cyc(1);
    if (!cnd(k)) begin
      $display("[FAIL] wait %0d expected 1 seen 0", k);
      fail_count++;
      end_sim();
    end
  endtask
  task automatic chk_out(input int s, input logic emu);
    chk("code", 32'(s), {30'h0, volt_code_bit1, volt_code_bit0});
    chk("lines", {28'h0, ~(4'h1 << s)}, {28'h0, lines});
    chk("emul", {31'h0, emu}, {31'h0, charger_emulation_enable});
    chk("supply", 32'h0, {31'h0, supply_enable_n});
  endtask
  initial begin
    logic [31:0] r;
    int s, cur, cnt, ev, q[$];
    void'($urandom(32'hc1b0dc57));
    // release on an edge; the flops leave reset at the edge after it
    repeat (5) @(posedge sys_clk);
    arst_n <= 1'b1;
    cyc(1);
    chk("supply", 32'h1, {31'h0, supply_enable_n});
    chk("lines", 32'he, {28'h0, lines});
    chk("fault", 32'h1, {31'h0, fault_pin});
    rd(4'h4, r);
    chk("state", 32'h1, r);
    rd(4'h6, r);
    chk("unmapped", 32'h0, r);
    rd(4'hc, r);
    chk("mask", 32'h0, r);
    $display("reset test done");
    for (int p = 0; p < 4; p++) begin
      @(posedge sys_clk);
      profile_select_0 <= p[0];
      profile_select_1 <= p[1];
      wr(4'h8, 32'h3f);
      wr(4'hc, (p == 0) ? 32'h0 : 32'h3f); // first pass runs masked
      cyc(4);
      @(posedge sys_clk);
      plug_detect_n <= 1'b0;
      wait_for(0, 20);
      chk_out(0, 1'b1);
      cyc(3);
      chk("irq", (p == 0) ? 32'h0 : 32'h1, {31'h0, irq});
      wr(4'h8, 32'h3f);
      cyc(3);
      chk("irq", 32'h0, {31'h0, irq});
      cnt = (tbl[p][3] == 0) ? 3 : 4;
      cur = 0;
      q = {};
      for (int k = 0; k < cnt + 6; k++)
        q.push_back(k < cnt ? k : (k == cnt ? 3 : $urandom % cnt));
      foreach (q[i]) begin
        s = q[i];
        wr(4'h0, 32'(s << 4) | 32'h1);
        cyc(2);
        if (s >= cnt) begin
          rd(4'h8, r);
          chk("badreq", 32'h1, (r >> 4) & 32'h1);
          wr(4'h8, 32'h10);
        end else begin
          chk("disch", 32'(s < cur), {31'h0, bus_discharge_enable});
          wait_for(1, 300);
          chk("stop", 32'h1, 32'(last_mv <= tbl[p][s] * 110 / 100));
          cur = s;
        end
        chk_out(cur, 1'b0);
        rd(4'h4, r);
        chk("state", 32'h4 | 32'(cur << 4) | 32'(p << 12), r & ~32'h100);
      end
      // drop the contract back to the safe level
      wr(4'h0, 32'h2);
      cyc(2);
      chk("disch", 32'(cur > 0), {31'h0, bus_discharge_enable});
      wait_for(1, 300);
      chk_out(0, 1'b1);
      // odd profiles take the fault pin, even ones an overshoot
      ev = p[0] ? 2 : 1;
      @(posedge sys_clk);
      if (p[0]) system_fault_in <= 1'b1;
      else ovr <= 1'b1;
      wait_for(2, 30);
      @(posedge sys_clk);
      system_fault_in <= 1'b0;
      ovr <= 1'b0;
      cyc(1);
      chk("off", 32'h1, {31'h0, supply_enable_n});
      chk("fault", 32'h0, {31'h0, fault_pin});
      rd(4'h8, r);
      chk("event", 32'h1, (r >> ev) & 32'h1);
      // the first pass runs with every event masked, so no interrupt
      chk("irq", (p == 0) ? 32'h0 : 32'h1, {31'h0, irq});
      wait_for(0, 100);
      chk("fault", 32'h1, {31'h0, fault_pin});
      chk_out(0, 1'b1);
      rd(4'h8, r);
      chk("restart", 32'h1, (r >> 5) & 32'h1);
      @(posedge sys_clk);
      plug_detect_n <= 1'b1;
      wait_for(3, 20);
      $display("profile %0d test done", p);
    end
    end_sim();
  end
endmodule
`default_nettype wire
